// file: hdl/lvds_pll_tuning_defines.vh
// register map, field positions and reset values of the pll tuning bank
// How it works
// R1 - five-bit phase detector field, bits 4-0
// R2 - two-bit loop filter capacitor field, bits 6-5
// R3 - bit 7 enables phase error reduction
// R4 - software keeps reduction bit at reset
// R5 - eight-bit fifo slip limit per frame
// R6 - software loads slip limit with 10h
// R7 - software loads per-resolution divider, enable, power values
// R8 - software loads common vco, amplitude, control values
// R9 - 71h holds feedback and feed-forward divider
// R10 - whole-byte writes, reads return stored value
`ifndef LVDS_PLL_TUNING_DEFINES_VH
`define LVDS_PLL_TUNING_DEFINES_VH
`define OFF_DIVIDER        10'h071
`define OFF_LINK_CTRL      10'h078
`define OFF_SLIP_LIMIT     10'h07F
`define RST_DIVIDER        8'hA3
`define RST_LINK_CTRL      8'h38
`define RST_SLIP_LIMIT     8'h10
`define PD_MSB             4
`define PD_LSB             0
`define LF_MSB             6
`define LF_LSB             5
`define PER_BIT            7
`define FBD_MSB            3
`define FBD_LSB            0
`define FFD_MSB            5
`define FFD_LSB            4
`endif

// file: hdl/tuning_reg8.v
// one eight-bit read/write register with reset value
`timescale 1ns/100ps
module tuning_reg8 #(
    parameter [7:0] RESET_VAL = 8'h00
) (
    // clock and reset
    input  wire       clk_in,
    input  wire       sys_rst_in,
    // write port
    input  wire       wr_en_in,
    input  wire [7:0] wr_data_in,
    // stored value
    output reg  [7:0] value_out
);
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            value_out <= RESET_VAL;
        end else if (wr_en_in) begin
            value_out <= wr_data_in; // [R10]
        end
    end
endmodule // tuning_reg8

// file: hdl/lvds_pll_tuning_regs.v
// apb register bank for the serial-link pll tuning fields
`timescale 1ns/100ps
`include "lvds_pll_tuning_defines.vh"
module lvds_pll_tuning_regs (
    // clock and reset
    input  wire        clk_in,
    input  wire        sys_rst_in,
    // apb slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output wire        pready_out,
    output wire        pslverr_out,
    output reg  [31:0] prdata_out,
    // pll tuning fields
    output wire [4:0]  phase_detector_setting_out,
    output wire [1:0]  loop_filter_setting_out,
    output wire        phase_error_reduction_en_out,
    output wire [3:0]  feedback_divider_out,
    output wire [1:0]  feedforward_divider_out,
    output wire [7:0]  fifo_slip_limit_out
);
    wire        wr_access;
    wire        hit_div;
    wire        hit_ctl;
    wire        hit_lim;
    wire        mapped;
    wire [7:0]  divider_q;
    wire [7:0]  link_pll_control_q;
    wire [7:0]  fifo_slip_limit_q;
    reg  [31:0] prdata_nxt;

    // address decode
    assign hit_div   = (paddr_in[11:2] == `OFF_DIVIDER);
    assign hit_ctl   = (paddr_in[11:2] == `OFF_LINK_CTRL);
    assign hit_lim   = (paddr_in[11:2] == `OFF_SLIP_LIMIT);
    assign mapped    = hit_div | hit_ctl | hit_lim;
    assign wr_access = psel_in & penable_in & pwrite_in;

    // zero wait states; unmapped access flags an error
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~mapped;

    tuning_reg8 #(.RESET_VAL(`RST_DIVIDER)) u_divider (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (wr_access & hit_div),
        .wr_data_in (pwdata_in[7:0]),
        .value_out  (divider_q)
    );

    tuning_reg8 #(.RESET_VAL(`RST_LINK_CTRL)) u_link_ctrl (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (wr_access & hit_ctl),
        .wr_data_in (pwdata_in[7:0]),
        .value_out  (link_pll_control_q)
    );

    tuning_reg8 #(.RESET_VAL(`RST_SLIP_LIMIT)) u_slip_limit (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_en_in   (wr_access & hit_lim), // [R5]
        .wr_data_in (pwdata_in[7:0]),
        .value_out  (fifo_slip_limit_q)
    );

    // field outputs
    assign phase_detector_setting_out =
        link_pll_control_q[`PD_MSB:`PD_LSB];               // [R1]
    assign loop_filter_setting_out =
        link_pll_control_q[`LF_MSB:`LF_LSB];               // [R2]
    assign phase_error_reduction_en_out =
        link_pll_control_q[`PER_BIT];                      // [R3]
    assign feedback_divider_out = divider_q[`FBD_MSB:`FBD_LSB]; // [R9]
    assign feedforward_divider_out = divider_q[`FFD_MSB:`FFD_LSB]; // [R9]
    assign fifo_slip_limit_out = fifo_slip_limit_q;        // [R5]

    // read mux, registered at the setup cycle
    always @* begin
        prdata_nxt = 32'h0000_0000;
        if (hit_div) begin
            prdata_nxt = {24'h00_0000, divider_q};         // [R10]
        end else if (hit_ctl) begin
            prdata_nxt = {24'h00_0000, link_pll_control_q}; // [R10]
        end else if (hit_lim) begin
            prdata_nxt = {24'h00_0000, fifo_slip_limit_q};  // [R10]
        end
    end

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in & ~penable_in) begin
            prdata_out <= prdata_nxt;
        end
    end
endmodule // lvds_pll_tuning_regs

// file: sim/lvds_pll_tuning_monitor.sv
// assertion checker for the pll tuning register bank
`timescale 1ns/100ps
module lvds_pll_tuning_monitor (
    input wire        clk_in, sys_rst_in, psel_in, penable_in, pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire        phase_error_reduction_en_out,
    input wire [1:0]  loop_filter_setting_out, feedforward_divider_out,
    input wire [4:0]  phase_detector_setting_out,
    input wire [3:0]  feedback_divider_out,
    input wire [7:0]  fifo_slip_limit_out,
    input wire        pready_out, pslverr_out,
    input wire [31:0] prdata_out);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    wire wr = psel_in & penable_in & pwrite_in;
    chk_ctl_write: assert property (
        wr && paddr_in == 12'h1E0 |=> {phase_error_reduction_en_out,
        loop_filter_setting_out, phase_detector_setting_out}
        == $past(pwdata_in[7:0])) else $error("control not written");
    chk_slip_write: assert property (
        wr && paddr_in == 12'h1FC |=> fifo_slip_limit_out
        == $past(pwdata_in[7:0])) else $error("slip limit not written");
    chk_div_write: assert property (
        wr && paddr_in == 12'h1C4 |=> {feedforward_divider_out,
        feedback_divider_out} == $past(pwdata_in[5:0]))
        else $error("divider not written");
    chk_slip_hold: assert property (
        !(wr && paddr_in == 12'h1FC) |=> $stable(fifo_slip_limit_out))
        else $error("slip limit changed");
    chk_ready_high: assert property (
        pready_out) else $error("ready not high");
    chk_unmapped_err: assert property (
        psel_in && penable_in && paddr_in[11:2] != 10'h071 &&
        paddr_in[11:2] != 10'h078 && paddr_in[11:2] != 10'h07F
        |-> pslverr_out) else $error("unmapped access without error");
    chk_read_ctl: assert property (
        psel_in && !penable_in && paddr_in == 12'h1E0 |=> prdata_out ==
        {24'h00_0000, phase_error_reduction_en_out,
        loop_filter_setting_out, phase_detector_setting_out})
        else $error("control read data wrong");
endmodule // lvds_pll_tuning_monitor
bind lvds_pll_tuning_regs lvds_pll_tuning_monitor i_mon (.*);

// file: sim/tb.sv
// self-checking bench for the pll tuning register bank
`timescale 1ns/100ps
module tb;
    logic clk_in = 0, sys_rst_in = 1, psel_in = 0, penable_in = 0;
    logic pwrite_in = 0, pready_out, pslverr_out;
    logic [11:0] paddr_in = 0;
    logic [31:0] pwdata_in = 0, prdata_out, r;
    logic [4:0] phase_detector_setting_out;
    logic [1:0] loop_filter_setting_out, feedforward_divider_out;
    logic [3:0] feedback_divider_out;
    logic [7:0] fifo_slip_limit_out;
    logic phase_error_reduction_en_out, e;
    int n_fail = 0, n_compared = 0;
    localparam [11:0] A_CTL = 12'h1E0, A_SLP = 12'h1FC, A_DIV = 12'h1C4;
    lvds_pll_tuning_regs i_lvds_pll_tuning_regs (.*);
    always #5 clk_in = ~clk_in;
    task chk(input [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            n_fail++; $display("MISMATCH %0t got %h exp %h", $time, s, e);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        int k;
        @(posedge clk_in); psel_in <= 1; pwrite_in <= w; paddr_in <= a;
        pwdata_in <= d; @(posedge clk_in); penable_in <= 1; k = 0;
        do begin @(posedge clk_in); k++; end while (pready_out !== 1 && k < 50);
        r = prdata_out; e = pslverr_out; psel_in <= 0; penable_in <= 0;
        if (k >= 50) begin n_fail++; complete_run; end
    endtask
    task t_write;
        logic [7:0] v[4] = '{8'h80, 8'h7F, 8'hAD, 8'hA3};
        apb(0, A_CTL, 0); chk(r, 32'h38);
        chk(e, 0);
        apb(0, A_SLP, 0); chk(fifo_slip_limit_out, 8'h10);
        foreach (v[i]) begin
            apb(1, A_CTL, {24'hFFFFFF, v[i]}); apb(1, A_DIV, {24'hFFFFFF, v[i]});
            apb(1, A_SLP, {24'hFFFFFF, v[i] ^ 8'hFF}); apb(0, A_CTL, 0);
            chk(r, v[i]);
            chk({phase_error_reduction_en_out, loop_filter_setting_out,
                phase_detector_setting_out}, v[i]);
            chk({feedforward_divider_out, feedback_divider_out}, v[i][5:0]);
            chk(fifo_slip_limit_out, v[i] ^ 8'hFF);
        end
        apb(1, 12'h1E4, 32'h55); chk(e, 1);
        apb(0, 12'h1E4, 0); chk(r, 0);
        $display("test write done");
    endtask
    task t_recommended;
        apb(1, A_CTL, 32'h80); apb(0, A_CTL, 0); chk(r, 32'h80);
        apb(1, A_CTL, 32'h3F); apb(0, A_CTL, 0);
        chk(phase_error_reduction_en_out, 0);
        apb(1, A_SLP, 32'h10); apb(0, A_SLP, 0);
        chk(fifo_slip_limit_out, 32'h10);
        apb(1, A_DIV, 32'hAD); apb(0, A_DIV, 0); chk(r, 32'hAD);
        chk({feedforward_divider_out, feedback_divider_out}, 32'h2D);
        apb(1, A_DIV, 32'hA3); apb(0, A_DIV, 0); chk(r, 32'hA3);
        $display("test recommended done");
    endtask
    task complete_run;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        sys_rst_in <= 0; t_write; t_recommended; complete_run;
    end
endmodule // tb
